// [tcr_pkg.sv]
package tcr_pkg;
  localparam int FIFO_W = 1;
  localparam int FIFO_D = 32;
  localparam int ID_W = 128;
  localparam int KEY_W = 128;
  localparam int FRAME_W = 136;
  localparam logic [3:0] BLK_OPT = 4'h0;
  localparam logic [3:0] BLK_LOCK = 4'h9;
  localparam logic [3:0] LOAD_LAST = 4'h9;
  localparam int OPT_RATE_BIT = 0;
  localparam int OPT_ENC_BIT = 1;
  localparam int LOCK_KEY_BIT = 0;
  localparam int LOCK_PW_BIT = 1;
  localparam logic [6:0] CRYPTO_BITS = 7'h42;
  localparam logic [1:0] OP_CRYPTO = 2'h1;
  localparam logic [4:0] ROUNDS = 5'h18;
  localparam logic [7:0] TERM_PAT = 8'hF0;
  localparam logic [7:0] CK_PAT = 8'h7E;
  localparam logic [7:0] LEN_ID = 8'h88;
  localparam logic [7:0] LEN_CK = 8'h0F;
  localparam logic [7:0] LEN_RESP = 8'h28;
  localparam logic [63:0] SBOX = 64'h5A3C_E1F0_8D27_B694;
  localparam int CLK_KHZ = 50000;
  localparam int CIPH_LIMIT_MS = 35;
  localparam int CIPH_LIMIT_CYC = CIPH_LIMIT_MS * CLK_KHZ;

  typedef struct packed {
    logic bit_strobe;
    logic bit_val;
    logic eot;
    logic err;
  } tcr_rx_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } tcr_mem_t;

  typedef enum logic [4:0] {
    ST_LOAD = 5'h01,
    ST_ID = 5'h02,
    ST_RX = 5'h04,
    ST_CIPH = 5'h08,
    ST_RESP = 5'h10
  } tcr_state_t;
endpackage : tcr_pkg

// [tcr_auth.sv]
`timescale 1ns/10ps
`default_nettype none

module tcr_fifo #(
  parameter int W = 1,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid_q,
  output logic [W-1:0] out_data_q,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = (cnt_q != '0) && (!out_valid_q || out_ready);
  assign in_ready = cnt_q != (AW+1)'(D);

  always_ff @(posedge core_clk) begin
    if (push) mem[wr_q] <= in_data;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (pop) out_data_q <= mem[rd_q];
      if (pop) out_valid_q <= 1'b1;
      else if (out_ready) out_valid_q <= 1'b0;
    end
  end
endmodule : tcr_fifo

// Functional notes
// - After reset load options from block 0, then send the identification code.
// - Op code 01 plus 64-bit challenge puts the block into authentication mode.
// - Challenge is decoded with part of the key back to the random number.
// - Wrong challenge bit count abandons authentication and resumes identification output.
// - While ciphering, loop a framed ones-count checksum; finish within 35 ms.
// - Cipher is a 64-bit transposition and substitution block cipher.
// - Cipher runs 24 rounds, each with its own key derived from secret key.
// - 64-bit cipher output is folded to a 32-bit response.
// - Response loops with terminator while powered.
// - Key in blocks 5..8; when locked, overwrite and direct read are refused (this block only reports the lock bit on key_protect_q).
// - Whole exchange should finish within 100 ms.
// - Valid authentication sequence is exactly 66 bits including op code.
// - Checksum bits go out least significant first.
// - A new challenge aborts the current computation and restarts authentication.
// - With password protection on, no response; return to identification after sequence.
module tcr_auth #(
  parameter int CIPH_LIMIT = tcr_pkg::CIPH_LIMIT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Memory read port
  output logic mem_rd_q,
  output logic [3:0] mem_addr_q,
  input wire tcr_pkg::tcr_mem_t mem_rsp,
  // Decoded write stream from the field demodulator
  input wire tcr_pkg::tcr_rx_t rx,
  // Transmit bit stream towards the modulator
  output logic tx_valid,
  output logic tx_bit,
  input wire logic tx_ready,
  // Options, protection and busy status
  output logic opt_rate_q,
  output logic opt_enc_q,
  output logic key_protect_q,
  output logic auth_busy_q
);
  tcr_pkg::tcr_state_t state_q, state_d;
  logic [3:0] idx_q;
  logic wait_q;
  logic pw_q;
  logic [tcr_pkg::ID_W-1:0] id_q;
  logic [tcr_pkg::KEY_W-1:0] key_q;
  logic [65:0] chal_q;
  logic [6:0] bitcnt_q;
  logic [63:0] x_q;
  logic [6:0] ones_q;
  logic [4:0] round_q;
  logic ck_sent_q;
  logic [31:0] wd_q;
  logic [tcr_pkg::FRAME_W-1:0] frame_q;
  logic [7:0] flen_q;

  function automatic logic [3:0] load_addr(input logic [3:0] i);
    return (i == 4'h0) ? tcr_pkg::BLK_OPT : (i == 4'h1) ? tcr_pkg::BLK_LOCK : 4'(i - 4'h1);
  endfunction : load_addr

  function automatic logic [6:0] ones(input logic [63:0] v);
    logic [6:0] n;
    n = '0;
    for (int i = 0; i < 64; i++) n = n + 7'(v[i]);
    return n;
  endfunction : ones

  function automatic logic [63:0] round_key(input logic [127:0] k, input logic [4:0] r);
    logic [255:0] t;
    t = {k, k} >> (r * 7);
    return t[63:0];
  endfunction : round_key

  function automatic logic [63:0] cipher_round(input logic [63:0] v, input logic [63:0] k);
    logic [63:0] y;
    y = v ^ k;
    for (int i = 0; i < 16; i++) y[i*4 +: 4] = tcr_pkg::SBOX[y[i*4 +: 4]*4 +: 4];
    return {y[50:0], y[63:51]};
  endfunction : cipher_round

  wire st_load = state_q == tcr_pkg::ST_LOAD;
  wire st_rx = state_q == tcr_pkg::ST_RX;
  wire st_ciph = state_q == tcr_pkg::ST_CIPH;
  wire [1:0] op_w = {chal_q[0], chal_q[1]};
  wire [63:0] chal_w = chal_q[65:2];
  wire seq_ok = (bitcnt_q == tcr_pkg::CRYPTO_BITS) && (op_w == tcr_pkg::OP_CRYPTO);
  wire cipher_done = round_q == tcr_pkg::ROUNDS;
  wire [31:0] resp_w = x_q[63:32] ^ {x_q[15:0], x_q[31:16]};
  wire load_last = st_load && mem_rsp.valid && (idx_q == tcr_pkg::LOAD_LAST);
  wire overflow = st_rx && rx.bit_strobe && (bitcnt_q == tcr_pkg::CRYPTO_BITS);
  wire wd_expired = wd_q == 32'(CIPH_LIMIT);
  wire fifo_ready;

  always_comb begin
    state_d = state_q;
    case (state_q)
      tcr_pkg::ST_LOAD: if (load_last) state_d = tcr_pkg::ST_ID;
      tcr_pkg::ST_RX: begin
        if (rx.err || overflow) state_d = tcr_pkg::ST_ID;
        else if (rx.eot && seq_ok && !pw_q) state_d = tcr_pkg::ST_CIPH;
        else if (rx.eot) state_d = tcr_pkg::ST_ID;
      end
      default: begin
        if (rx.err) state_d = tcr_pkg::ST_ID;
        else if (rx.bit_strobe) state_d = tcr_pkg::ST_RX;
        else if (st_ciph && wd_expired) state_d = tcr_pkg::ST_ID;
        else if (st_ciph && cipher_done && ck_sent_q && flen_q == 8'h00) state_d = tcr_pkg::ST_RESP;
      end
    endcase
  end

  // Power-up load: options, lock word, identification, key
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx_q <= '0;
      wait_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_addr_q <= '0;
      opt_rate_q <= 1'b0;
      opt_enc_q <= 1'b0;
      key_protect_q <= 1'b0;
      pw_q <= 1'b0;
      id_q <= '0;
      key_q <= '0;
    end else begin
      mem_rd_q <= st_load && !wait_q && !mem_rd_q;
      mem_addr_q <= load_addr(idx_q);
      if (mem_rd_q) wait_q <= 1'b1;
      if (st_load && mem_rsp.valid) begin
        wait_q <= 1'b0;
        idx_q <= idx_q + 4'h1;
        if (idx_q == 4'h0) begin
          opt_rate_q <= mem_rsp.data[tcr_pkg::OPT_RATE_BIT];
          opt_enc_q <= mem_rsp.data[tcr_pkg::OPT_ENC_BIT];
        end else if (idx_q == 4'h1) begin
          key_protect_q <= mem_rsp.data[tcr_pkg::LOCK_KEY_BIT];
          pw_q <= mem_rsp.data[tcr_pkg::LOCK_PW_BIT];
        end else if (idx_q < 4'h6) id_q <= {mem_rsp.data, id_q[127:32]};
        else key_q <= {mem_rsp.data, key_q[127:32]};
      end
    end
  end

  // Challenge reception and cipher
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= tcr_pkg::ST_LOAD;
      chal_q <= '0;
      bitcnt_q <= '0;
      x_q <= '0;
      ones_q <= '0;
      round_q <= '0;
      wd_q <= '0;
      auth_busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      auth_busy_q <= state_d == tcr_pkg::ST_CIPH;
      if (!st_load && rx.bit_strobe) begin
        chal_q <= {rx.bit_val, chal_q[65:1]};
        bitcnt_q <= st_rx ? bitcnt_q + 7'h01 : 7'h01;
      end
      if (st_rx && state_d == tcr_pkg::ST_CIPH) begin
        x_q <= chal_w ^ key_q[63:0];
        ones_q <= ones(chal_w);
        round_q <= '0;
      end else if (st_ciph && !cipher_done) begin
        x_q <= cipher_round(x_q, round_key(key_q, round_q));
        round_q <= round_q + 5'h01;
      end
      wd_q <= st_ciph ? wd_q + 32'h1 : '0;
    end
  end

  // Frame builder feeding the transmit FIFO, sent least significant bit first
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_q <= '0;
      flen_q <= '0;
      ck_sent_q <= 1'b0;
    end else begin
      if (st_rx) ck_sent_q <= 1'b0;
      if (flen_q != 8'h00) begin
        if (fifo_ready) begin
          frame_q <= frame_q >> 1;
          flen_q <= flen_q - 8'h01;
        end
      end else if (state_q == tcr_pkg::ST_ID) begin
        frame_q <= {tcr_pkg::TERM_PAT, id_q};
        flen_q <= tcr_pkg::LEN_ID;
      end else if (st_ciph) begin
        frame_q <= {121'h0, ones_q, tcr_pkg::CK_PAT};
        flen_q <= tcr_pkg::LEN_CK;
        ck_sent_q <= 1'b1;
      end else if (state_q == tcr_pkg::ST_RESP) begin
        frame_q <= {96'h0, tcr_pkg::TERM_PAT, resp_w};
        flen_q <= tcr_pkg::LEN_RESP;
      end
    end
  end

  tcr_fifo #(.W(tcr_pkg::FIFO_W), .D(tcr_pkg::FIFO_D)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(flen_q != 8'h00),
    .in_data(frame_q[0]),
    .in_ready(fifo_ready),
    .out_valid_q(tx_valid),
    .out_data_q(tx_bit),
    .out_ready(tx_ready)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_load_first;
    (st_load && mem_rd_q && idx_q == 4'h0) |-> mem_addr_q == tcr_pkg::BLK_OPT;
  endproperty
  a_load_first: assert property (p_load_first) else $error("first load not block 0");

  property p_id_after_load;
    load_last |=> state_q == tcr_pkg::ST_ID ##1 flen_q == tcr_pkg::LEN_ID;
  endproperty
  a_id_after_load: assert property (p_id_after_load) else $error("no id after load");

  property p_enter_cipher;
    (st_rx && !rx.err && rx.eot && seq_ok && !pw_q) |=> st_ciph && round_q == 5'h00;
  endproperty
  a_enter_cipher: assert property (p_enter_cipher) else $error("valid challenge not taken");

  property p_decode;
    (st_rx && state_d == tcr_pkg::ST_CIPH) |=> x_q == ($past(chal_w) ^ key_q[63:0]);
  endproperty
  a_decode: assert property (p_decode) else $error("challenge not decoded");

  property p_overflow;
    (overflow && !rx.err) |=> state_q == tcr_pkg::ST_ID;
  endproperty
  a_overflow: assert property (p_overflow) else $error("bit overflow not aborted");

  property p_rounds;
    (st_ciph && round_q == 5'h00 && !rx.bit_strobe && !rx.err) |-> ##[24:24] cipher_done || !st_ciph;
  endproperty
  a_rounds: assert property (p_rounds) else $error("round count wrong");

  property p_password;
    (st_rx && !rx.err && rx.eot && pw_q) |=> state_q == tcr_pkg::ST_ID;
  endproperty
  a_password: assert property (p_password) else $error("response computed under password");

  property p_ck_frame;
    (st_ciph && flen_q == 8'h00) |=> flen_q == tcr_pkg::LEN_CK && frame_q[7:0] == tcr_pkg::CK_PAT;
  endproperty
  a_ck_frame: assert property (p_ck_frame) else $error("checksum frame wrong");

  property p_resp_frame;
    (state_q == tcr_pkg::ST_RESP && flen_q == 8'h00) |=> frame_q[39:32] == tcr_pkg::TERM_PAT;
  endproperty
  a_resp_frame: assert property (p_resp_frame) else $error("response frame wrong");

  c_resp: cover property (st_ciph ##1 state_q == tcr_pkg::ST_RESP);
  c_pw_reject: cover property (st_rx && rx.eot && pw_q);
  c_restart: cover property (st_ciph && rx.bit_strobe);
endmodule : tcr_auth

`default_nettype wire

// [tcr_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module tcr_mem_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Block read port
  input wire logic mem_rd_q,
  input wire logic [3:0] mem_addr_q,
  output var tcr_pkg::tcr_mem_t mem_rsp,
  // Lock word contents
  input wire logic [31:0] lock_word
);
  logic [3:0] addr_q;
  logic [1:0] wait_q;
  logic pend_q;
  logic slow_q;
  logic [31:0] blk_data;
  // Options: rate set, encoding follows the password bit so both levels get seen
  assign blk_data = (addr_q == tcr_pkg::BLK_OPT) ? {30'h0, lock_word[1], 1'b1} :
    (addr_q == tcr_pkg::BLK_LOCK) ? lock_word : {4'hC, addr_q, 24'h5A_3961};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      slow_q <= 1'b0;
      wait_q <= 2'h0;
      addr_q <= 4'h0;
      mem_rsp <= {1'b0, 32'h0};
    end else if (mem_rd_q) begin
      pend_q <= 1'b1;
      addr_q <= mem_addr_q;
      // Alternate prompt and slow answers
      wait_q <= slow_q ? 2'h3 : 2'h0;
      slow_q <= ~slow_q;
      mem_rsp.valid <= 1'b0;
    end else if (pend_q && wait_q == 2'h0) begin
      pend_q <= 1'b0;
      mem_rsp <= {1'b1, blk_data};
    end else begin
      wait_q <= wait_q - 2'h1;
      // Idle bus flips so stale data never looks valid
      mem_rsp <= {1'b0, ~mem_rsp.data};
    end
  end
endmodule : tcr_mem_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk;
  logic rst;
  logic mem_rd_q;
  logic [3:0] mem_addr_q;
  tcr_pkg::tcr_mem_t mem_rsp;
  tcr_pkg::tcr_rx_t rx;
  logic tx_valid;
  logic tx_bit;
  logic tx_ready;
  logic opt_rate_q;
  logic opt_enc_q;
  logic key_protect_q;
  logic auth_busy_q;
  logic [31:0] lock_word;
  int num_errors;
  int comparisons;
  int cycles;
  logic txq[$];
  logic [3:0] addr_log[$];
  localparam logic [127:0] ID_EXP = 128'hC45A3961_C35A3961_C25A3961_C15A3961;
  localparam logic [127:0] KEY_EXP = 128'hC85A3961_C75A3961_C65A3961_C55A3961;

  tcr_auth #(.CIPH_LIMIT(2000)) tcr_auth_i (.core_clk(core_clk), .rst(rst), .mem_rd_q(mem_rd_q),
    .mem_addr_q(mem_addr_q), .mem_rsp(mem_rsp), .rx(rx), .tx_valid(tx_valid), .tx_bit(tx_bit),
    .tx_ready(tx_ready), .opt_rate_q(opt_rate_q), .opt_enc_q(opt_enc_q),
    .key_protect_q(key_protect_q), .auth_busy_q(auth_busy_q));
  tcr_mem_model tcr_mem_model_i (.core_clk(core_clk), .rst(rst), .mem_rd_q(mem_rd_q),
    .mem_addr_q(mem_addr_q), .mem_rsp(mem_rsp), .lock_word(lock_word));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    // Modulator stalls one cycle in seven
    tx_ready <= (cycles % 7) != 3;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end
  always @(negedge core_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_bit);
    if (mem_rd_q === 1'b1) addr_log.push_back(mem_addr_q);
  end

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check_vec(input string name, input logic [127:0] exp, input logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check_vec

  task automatic get_bits(input int n, output logic [127:0] v);
    v = 128'h0;
    for (int i = 0; i < n; i++) begin
      while (txq.size() == 0) @(negedge core_clk);
      v[i] = txq.pop_front();
    end
  endtask : get_bits

  task automatic sync(input logic [7:0] pat);
    logic [7:0] sr;
    logic [127:0] v;
    sr = ~pat;
    for (int i = 0; i < 400 && sr !== pat; i++) begin
      get_bits(1, v);
      sr = {v[0], sr[7:1]};
    end
  endtask : sync

  // Frames loop, so old traffic may precede the one wanted
  task automatic seek(input logic [7:0] pat, input int n, input logic [127:0] exp, input string name);
    logic [127:0] v;
    for (int t = 0; t < 6; t++) begin
      sync(pat);
      get_bits(n, v);
      if (v === exp) break;
    end
    check_vec(name, exp, v);
  endtask : seek

  task automatic send(input int n, input logic [66:0] seq, input logic err);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk) rx <= {1'b1, seq[i], 2'h0};
      @(posedge core_clk) rx <= 4'h0;
    end
    @(posedge core_clk) rx <= err ? 4'h1 : 4'h2;
    @(posedge core_clk) rx <= 4'h0;
  endtask : send

  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 300 && auth_busy_q !== lvl; i++) @(negedge core_clk);
    check_vec("auth_busy", lvl, auth_busy_q);
  endtask : wait_busy

  task automatic t_power(input logic [31:0] lock);
    logic [127:0] v;
    @(posedge core_clk);
    rst <= 1'b1;
    lock_word <= lock;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    txq.delete();
    addr_log.delete();
    get_bits(128, v);
    check_vec("id_code", ID_EXP, v);
    get_bits(8, v);
    check_vec("id_term", 8'hF0, v);
    v = 128'h0;
    foreach (addr_log[i]) v[4 * i +: 4] = addr_log[i];
    check_vec("load_order", 40'h87654321_90, v);
    check_vec("options", {lock[1], 1'b1}, {opt_enc_q, opt_rate_q});
    check_vec("key_lock", lock[0], key_protect_q);
  endtask : t_power

  // Reference cipher built from the agreed stand-in round, key schedule and fold
  function automatic logic [31:0] ref_resp(input logic [63:0] chal);
    logic [255:0] kk;
    logic [63:0] x;
    logic [63:0] y;
    kk = {KEY_EXP, KEY_EXP};
    x = chal ^ KEY_EXP[63:0];
    for (int r = 0; r < 24; r++) begin
      y = x ^ 64'(kk >> (r * 7));
      for (int n = 0; n < 16; n++) y[n*4 +: 4] = tcr_pkg::SBOX[y[n*4 +: 4]*4 +: 4];
      x = {y[50:0], y[63:51]};
    end
    return x[63:32] ^ {x[15:0], x[31:16]};
  endfunction : ref_resp

  task automatic t_auth(input logic [63:0] chal);
    logic [127:0] a;
    logic [127:0] b;
    send(66, {1'b0, chal, 2'h2}, 1'b0);
    wait_busy(1'b1);
    seek(8'h7E, 7, $countones(chal), "checksum");
    wait_busy(1'b0);
    seek(8'hF0, 32, ref_resp(chal), "response");
    get_bits(8, a);
    check_vec("resp_term", 8'hF0, a);
    get_bits(40, a);
    get_bits(40, b);
    check_vec("resp_loop", a, b);
  endtask : t_auth

  task automatic t_restart(input logic [63:0] old_chal, input logic [63:0] chal);
    send(66, {1'b0, old_chal, 2'h2}, 1'b0);
    wait_busy(1'b1);
    t_auth(chal);
  endtask : t_restart

  task automatic t_password();
    send(66, {1'b0, 64'h0123_4567_89AB_CDEF, 2'h2}, 1'b0);
    repeat (2) @(negedge core_clk);
    check_vec("busy_pw", 1'b0, auth_busy_q);
    seek(8'hF0, 128, ID_EXP, "id_pw");
  endtask : t_password

  task automatic t_bad(input int n, input logic [66:0] seq, input logic err);
    send(n, seq, err);
    seek(8'hF0, 128, ID_EXP, "id_after_error");
  endtask : t_bad

  initial begin
    rst = 1'b1;
    rx = 4'h0;
    tx_ready = 1'b0;
    lock_word = 32'h0;
    cycles = 0;
    num_errors = 0;
    comparisons = 0;
    t_power(32'h0000_0001);
    t_auth(64'h0123_4567_89AB_CDEF);
    t_restart(64'h5555_AAAA_0F0F_3C3C, 64'hFFFF_0000_FFFF_00FF);
    t_bad(65, {1'b0, 64'hFF, 2'h2}, 1'b0);
    t_bad(67, {1'b1, 64'hFF, 2'h2}, 1'b0);
    t_bad(10, {67'h2}, 1'b1);
    t_bad(66, {1'b0, 64'hFF, 2'h3}, 1'b0);
    t_power(32'h0000_0003);
    t_password();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
